/* hdl/pcx_pkg.sv */
package pcx_pkg;

    // ****************************************
    // branch opcodes, high byte of the word
    // ****************************************
    localparam logic [7:0] OP_BR = 8'h01;
    localparam logic [7:0] OP_BNE = 8'h02;
    localparam logic [7:0] OP_BEQ = 8'h03;
    localparam logic [7:0] OP_BGE = 8'h04;
    localparam logic [7:0] OP_BLT = 8'h05;
    localparam logic [7:0] OP_BGT = 8'h06;
    localparam logic [7:0] OP_BLE = 8'h07;
    localparam logic [7:0] OP_BMI = 8'h81;
    localparam logic [7:0] OP_BHI = 8'h82;
    localparam logic [7:0] OP_BRANCH_LOWER_SAME_UNSIGNED = 8'h83;
    localparam logic [7:0] OP_BCC = 8'h86;

    // ****************************************
    // other program-control opcodes
    // ****************************************
    localparam logic [9:0] OP_JMP = 10'h001;
    localparam logic [6:0] OP_JSR = 7'h04;
    localparam logic [12:0] OP_RTS = 13'h0010;
    localparam logic [9:0] OP_MARK = 10'h034;
    localparam logic [6:0] OP_SOB = 7'h3f;
    localparam logic [15:0] OP_RTI = 16'h0002;
    localparam logic [15:0] OP_RTT = 16'h0006;

    // ****************************************
    // modes, registers, vectors
    // ****************************************
    localparam logic [2:0] MODE_REG = 3'h0;
    localparam logic [2:0] MODE_DEFER = 3'h1;
    localparam logic [2:0] MODE_AINC_DEF = 3'h3;
    localparam logic [2:0] REG_FRAME = 3'h5;
    localparam logic [2:0] REG_SP = 3'h6;
    localparam logic [2:0] REG_PC = 3'h7;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] VEC_BUS_ERR = 16'h0004;
    localparam logic [15:0] VEC_ILLEGAL = 16'h0004;
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;

    // ****************************************
    // register map and fields
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_PC = 8'h10;
    localparam logic [7:0] ADDR_PSW = 8'h14;
    localparam int CTRL_EN = 0;
    localparam int EV_W = 4;
    localparam int EV_ILLEGAL = 0;
    localparam int EV_ODD = 1;
    localparam int EV_TRAP = 2;
    localparam int EV_RETURN = 3;

    typedef enum logic [3:0] {
        ST_IDLE, ST_PUSH_PS, ST_PUSH_PC, ST_VEC_PC, ST_VEC_PS, ST_POP_PC,
        ST_POP_PS, ST_CALL_PUSH, ST_POP_REG, ST_SWAP_RD, ST_SWAP_WR
    } pcx_state_t;

endpackage : pcx_pkg

/* hdl/pcx_branch_eval.sv */
`timescale 1ns/1ps

module pcx_branch_eval (
    input wire logic [15:0] word,
    input wire logic [15:0] base,
    input wire logic [3:0] flags,
    output logic is_branch,
    output logic taken,
    output logic [15:0] target
);

    // sign-extend the 8-bit word offset and make it bytes
    function automatic logic [15:0] byte_offset(input logic [7:0] off);
        byte_offset = {{7{off[7]}}, off, 1'b0};
    endfunction : byte_offset

    logic n;
    logic z;
    logic v;
    logic c;

    // ****************************************
    // condition test
    // ****************************************
    always_comb
    begin
        n = flags[pcx_pkg::FLAG_N];
        z = flags[pcx_pkg::FLAG_Z];
        v = flags[pcx_pkg::FLAG_V];
        c = flags[pcx_pkg::FLAG_C];
        is_branch = 1'b1;
        case (word[15:8])
            pcx_pkg::OP_BR: taken = 1'b1;
            pcx_pkg::OP_BNE: taken = !z;
            pcx_pkg::OP_BEQ: taken = z;
            pcx_pkg::OP_BGE: taken = !(n ^ v);
            pcx_pkg::OP_BLT: taken = n ^ v;
            pcx_pkg::OP_BGT: taken = !(z | (n ^ v)); // RULE1
            pcx_pkg::OP_BLE: taken = z | (n ^ v); // RULE2
            pcx_pkg::OP_BMI: taken = n;
            pcx_pkg::OP_BHI: taken = !c && !z; // RULE3
            pcx_pkg::OP_BRANCH_LOWER_SAME_UNSIGNED: taken = c | z; // RULE4
            pcx_pkg::OP_BCC: taken = !c;
            default:
            begin
                is_branch = 1'b0;
                taken = 1'b0;
            end
        endcase
        target = base + byte_offset(word[7:0]); // RULE5 RULE6
    end

endmodule : pcx_branch_eval

/* hdl/pcx_exec.sv */
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps

// Summary of operation
// RULE1 - greater signed branches unless Z or N^V
// RULE2 - less-equal signed branches when Z or N^V
// RULE3 - higher unsigned branches when C and Z clear
// RULE4 - lower-same unsigned branches when C or Z
// RULE5 - offset sign-extended, doubled, added to base
// RULE6 - branch base is instruction address plus two
// RULE7 - branches never touch condition codes
// RULE8 - jump loads destination; register mode traps illegal
// RULE9 - deferred jump goes to register contents
// RULE10 - odd fetch address raises boundary error trap
// RULE11 - call: temp, push reg, reg=pc, pc=temp
// RULE12 - call via pc changes only sp, pc
// RULE13 - call pc through (sp)+ swaps stack top
// RULE14 - return: pc=reg, then pop into reg
// RULE15 - cleanup: sp+=2nn, pc=frame, pop frame
// RULE16 - loop: decrement, nonzero branches backward only
// RULE17 - trap pushes psw, pc, loads vector pair
// RULE18 - trap return pops pc then psw
// RULE19 - push predecrements two, pop postincrements two

module pcx_exec #(
    parameter logic [15:0] RESET_PC = 16'h0000,
    parameter logic [15:0] RESET_SP = 16'h0000
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [15:0] fetch_addr,
    input wire logic ins_valid,
    input wire logic [15:0] ins_word,
    input wire logic [15:0] ins_dst,
    output logic ins_ready,
    input wire logic trap_req,
    input wire logic [15:0] trap_vec,
    output logic trap_ack,
    input wire logic psw_wr,
    input wire logic [15:0] psw_wdata,
    output logic [15:0] psw_out,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);

    pcx_pkg::pcx_state_t state_reg, state_next;
    logic [15:0] gpr_reg [0:7];
    logic [15:0] gpr_next [0:7];
    logic [15:0] psw_reg, psw_next, tmp_reg, tmp_next, vec_reg, vec_next;
    logic [2:0] sel_reg, sel_next;
    logic mreq_reg, mreq_next, mwe_reg, mwe_next;
    logic [15:0] maddr_reg, maddr_next, mwdata_reg, mwdata_next;
    logic [pcx_pkg::EV_W-1:0] ev;
    logic [pcx_pkg::EV_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
    logic ctrl_reg, ctrl_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [15:0] pc, sp, upd, dreg_val, br_target, sob_cnt;
    logic [2:0] mode, rsel;
    logic br_is, br_take, acc, trap_go, apb_wr, mapped;
    logic [15:0] trap_to;

    assign pc = gpr_reg[pcx_pkg::REG_PC];
    assign sp = gpr_reg[pcx_pkg::REG_SP];
    assign upd = pc + pcx_pkg::WORD_STEP; // RULE6
    assign mode = ins_word[5:3];
    assign rsel = ins_word[8:6];
    assign dreg_val = (ins_word[2:0] == pcx_pkg::REG_PC) ? upd : gpr_reg[ins_word[2:0]];
    assign sob_cnt = gpr_reg[rsel] - 16'h0001;
    assign acc = ins_valid && ins_ready;

    // branch condition and target
    pcx_branch_eval u_branch (
        .word(ins_word),
        .base(upd),
        .flags(psw_reg[3:0]),
        .is_branch(br_is),
        .taken(br_take),
        .target(br_target)
    );

    // ****************************************
    // execution sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        gpr_next = gpr_reg;
        psw_next = psw_reg;
        tmp_next = tmp_reg;
        vec_next = vec_reg;
        sel_next = sel_reg;
        mreq_next = mreq_reg;
        mwe_next = mwe_reg;
        maddr_next = maddr_reg;
        mwdata_next = mwdata_reg;
        ev = '0;
        ins_ready = 1'b0;
        trap_ack = 1'b0;
        trap_go = 1'b0;
        trap_to = trap_vec;
        case (state_reg)
            pcx_pkg::ST_IDLE:
            begin
                if (psw_wr)
                    psw_next = psw_wdata;
                ins_ready = ctrl_reg && !pc[0] && !trap_req;
                if (ctrl_reg && pc[0])
                begin
                    trap_go = 1'b1; // RULE10
                    trap_to = pcx_pkg::VEC_BUS_ERR;
                    ev[pcx_pkg::EV_ODD] = 1'b1;
                end
                else if (ctrl_reg && trap_req)
                begin
                    trap_go = 1'b1;
                    trap_ack = 1'b1;
                end
                else if (acc)
                begin
                    gpr_next[pcx_pkg::REG_PC] = upd;
                    if (br_is)
                    begin
                        if (br_take)
                            gpr_next[pcx_pkg::REG_PC] = br_target; // RULE5 RULE7
                    end
                    else if (ins_word[15:6] == pcx_pkg::OP_JMP
                             || ins_word[15:9] == pcx_pkg::OP_JSR)
                    begin
                        tmp_next = (mode == pcx_pkg::MODE_DEFER) ? dreg_val : ins_dst; // RULE9 RULE11
                        sel_next = rsel;
                        if (mode == pcx_pkg::MODE_REG)
                        begin
                            trap_go = 1'b1; // RULE8
                            trap_to = pcx_pkg::VEC_ILLEGAL;
                            ev[pcx_pkg::EV_ILLEGAL] = 1'b1;
                        end
                        else if (ins_word[15:6] == pcx_pkg::OP_JMP)
                            gpr_next[pcx_pkg::REG_PC] = tmp_next; // RULE8
                        else if (rsel == pcx_pkg::REG_PC && mode == pcx_pkg::MODE_AINC_DEF
                                 && ins_word[2:0] == pcx_pkg::REG_SP)
                        begin
                            state_next = pcx_pkg::ST_SWAP_RD; // RULE13
                            mreq_next = 1'b1;
                            mwe_next = 1'b0;
                            maddr_next = sp;
                        end
                        else
                        begin
                            state_next = pcx_pkg::ST_CALL_PUSH; // RULE11 RULE12 RULE19
                            gpr_next[pcx_pkg::REG_SP] = sp - pcx_pkg::WORD_STEP;
                            mreq_next = 1'b1;
                            mwe_next = 1'b1;
                            maddr_next = sp - pcx_pkg::WORD_STEP;
                            mwdata_next = (rsel == pcx_pkg::REG_PC) ? upd : gpr_reg[rsel];
                        end
                    end
                    else if (ins_word[15:3] == pcx_pkg::OP_RTS)
                    begin
                        gpr_next[pcx_pkg::REG_PC] = dreg_val; // RULE14
                        sel_next = ins_word[2:0];
                        state_next = pcx_pkg::ST_POP_REG;
                        mreq_next = 1'b1;
                        mwe_next = 1'b0;
                        maddr_next = sp;
                    end
                    else if (ins_word[15:6] == pcx_pkg::OP_MARK)
                    begin
                        gpr_next[pcx_pkg::REG_SP] = sp + {9'h000, ins_word[5:0], 1'b0}; // RULE15
                        gpr_next[pcx_pkg::REG_PC] = gpr_reg[pcx_pkg::REG_FRAME];
                        sel_next = pcx_pkg::REG_FRAME;
                        state_next = pcx_pkg::ST_POP_REG;
                        mreq_next = 1'b1;
                        mwe_next = 1'b0;
                        maddr_next = gpr_next[pcx_pkg::REG_SP];
                    end
                    else if (ins_word[15:9] == pcx_pkg::OP_SOB)
                    begin
                        gpr_next[rsel] = sob_cnt; // RULE16
                        if (sob_cnt != 16'h0000)
                            gpr_next[pcx_pkg::REG_PC] = upd - {9'h000, ins_word[5:0], 1'b0};
                    end
                    else if (ins_word == pcx_pkg::OP_RTI || ins_word == pcx_pkg::OP_RTT)
                    begin
                        state_next = pcx_pkg::ST_POP_PC; // RULE18
                        mreq_next = 1'b1;
                        mwe_next = 1'b0;
                        maddr_next = sp;
                    end
                end
                if (trap_go)
                begin
                    ev[pcx_pkg::EV_TRAP] = 1'b1;
                    vec_next = trap_to;
                    state_next = pcx_pkg::ST_PUSH_PS; // RULE17 RULE19
                    gpr_next[pcx_pkg::REG_SP] = sp - pcx_pkg::WORD_STEP;
                    mreq_next = 1'b1;
                    mwe_next = 1'b1;
                    maddr_next = sp - pcx_pkg::WORD_STEP;
                    mwdata_next = psw_reg;
                end
            end
            pcx_pkg::ST_PUSH_PS:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_PUSH_PC; // RULE17 RULE19
                    gpr_next[pcx_pkg::REG_SP] = sp - pcx_pkg::WORD_STEP;
                    maddr_next = sp - pcx_pkg::WORD_STEP;
                    mwdata_next = pc;
                end
            pcx_pkg::ST_PUSH_PC:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_VEC_PC;
                    mwe_next = 1'b0;
                    maddr_next = vec_reg;
                end
            pcx_pkg::ST_VEC_PC:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_VEC_PS; // RULE17
                    gpr_next[pcx_pkg::REG_PC] = mem_rdata;
                    maddr_next = vec_reg + pcx_pkg::WORD_STEP;
                end
            pcx_pkg::ST_VEC_PS:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_IDLE;
                    psw_next = mem_rdata;
                    mreq_next = 1'b0;
                end
            pcx_pkg::ST_POP_PC:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_POP_PS; // RULE18 RULE19
                    gpr_next[pcx_pkg::REG_PC] = mem_rdata;
                    gpr_next[pcx_pkg::REG_SP] = sp + pcx_pkg::WORD_STEP;
                    maddr_next = sp + pcx_pkg::WORD_STEP;
                end
            pcx_pkg::ST_POP_PS:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_IDLE; // RULE18
                    psw_next = mem_rdata;
                    gpr_next[pcx_pkg::REG_SP] = sp + pcx_pkg::WORD_STEP;
                    mreq_next = 1'b0;
                    ev[pcx_pkg::EV_RETURN] = 1'b1;
                end
            pcx_pkg::ST_CALL_PUSH:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_IDLE; // RULE11 RULE12
                    gpr_next[sel_reg] = pc;
                    gpr_next[pcx_pkg::REG_PC] = tmp_reg;
                    mreq_next = 1'b0;
                end
            pcx_pkg::ST_POP_REG:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_IDLE; // RULE14 RULE15 RULE19
                    gpr_next[pcx_pkg::REG_SP] = sp + pcx_pkg::WORD_STEP;
                    gpr_next[sel_reg] = mem_rdata;
                    mreq_next = 1'b0;
                end
            pcx_pkg::ST_SWAP_RD:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_SWAP_WR; // RULE13
                    tmp_next = mem_rdata;
                    mwe_next = 1'b1;
                    mwdata_next = pc;
                end
            pcx_pkg::ST_SWAP_WR:
                if (mem_ack)
                begin
                    state_next = pcx_pkg::ST_IDLE; // RULE13
                    gpr_next[pcx_pkg::REG_PC] = tmp_reg;
                    mreq_next = 1'b0;
                end
            default:
            begin
                state_next = pcx_pkg::ST_IDLE;
                mreq_next = 1'b0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_reg <= pcx_pkg::ST_IDLE;
            for (int i = 0; i < 8; i++)
                gpr_reg[i] <= 16'h0000;
            gpr_reg[pcx_pkg::REG_PC] <= RESET_PC;
            gpr_reg[pcx_pkg::REG_SP] <= RESET_SP;
            psw_reg <= 16'h0000;
            tmp_reg <= 16'h0000;
            vec_reg <= 16'h0000;
            sel_reg <= 3'h0;
            mreq_reg <= 1'b0;
            mwe_reg <= 1'b0;
            maddr_reg <= 16'h0000;
            mwdata_reg <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            gpr_reg <= gpr_next;
            psw_reg <= psw_next;
            tmp_reg <= tmp_next;
            vec_reg <= vec_next;
            sel_reg <= sel_next;
            mreq_reg <= mreq_next;
            mwe_reg <= mwe_next;
            maddr_reg <= maddr_next;
            mwdata_reg <= mwdata_next;
        end
    end

    assign fetch_addr = pc;
    assign psw_out = psw_reg;
    assign mem_req = mreq_reg;
    assign mem_we = mwe_reg;
    assign mem_addr = maddr_reg;
    assign mem_wdata = mwdata_reg;

    // ****************************************
    // apb register slave
    // ****************************************
    always_comb
    begin
        apb_wr = psel && penable && pwrite;
        mapped = 1'b1;
        prdata_next = prdata_reg;
        ctrl_next = ctrl_reg;
        imask_next = imask_reg;
        ist_next = ist_reg;
        if (apb_wr && paddr == pcx_pkg::ADDR_CTRL)
            ctrl_next = pwdata[pcx_pkg::CTRL_EN];
        if (apb_wr && paddr == pcx_pkg::ADDR_IRQ_MASK)
            imask_next = pwdata[pcx_pkg::EV_W-1:0];
        if (apb_wr && paddr == pcx_pkg::ADDR_IRQ_STAT)
            ist_next = ist_reg & ~pwdata[pcx_pkg::EV_W-1:0];
        ist_next = ist_next | ev; // set wins over clear
        case (paddr)
            pcx_pkg::ADDR_CTRL: prdata_next = {31'h0000_0000, ctrl_reg};
            pcx_pkg::ADDR_STAT: prdata_next = {27'h000_0000, mreq_reg, state_reg};
            pcx_pkg::ADDR_IRQ_STAT: prdata_next = {28'h000_0000, ist_reg};
            pcx_pkg::ADDR_IRQ_MASK: prdata_next = {28'h000_0000, imask_reg};
            pcx_pkg::ADDR_PC: prdata_next = {16'h0000, pc};
            pcx_pkg::ADDR_PSW: prdata_next = {16'h0000, psw_reg};
            default:
            begin
                prdata_next = 32'h0000_0000;
                mapped = 1'b0;
            end
        endcase
        if (!(psel && !penable))
            prdata_next = prdata_reg; // capture in setup phase only
    end

    // register file and read data
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ctrl_reg <= 1'b0;
            imask_reg <= '0;
            ist_reg <= '0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            imask_reg <= imask_next;
            ist_reg <= ist_next;
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign irq = |(ist_reg & imask_reg);

    // ****************************************
    // checks
    // ****************************************
    gt_zero_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
        acc && ins_word[15:8] == pcx_pkg::OP_BGT && psw_reg[pcx_pkg::FLAG_Z] |=> pc == $past(upd))
        else $error("greater branch taken on zero");
    le_zero_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE2
        acc && ins_word[15:8] == pcx_pkg::OP_BLE && psw_reg[pcx_pkg::FLAG_Z] |=> pc == $past(br_target))
        else $error("less-equal branch missed on zero");
    hi_skip_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE3
        acc && ins_word[15:8] == pcx_pkg::OP_BHI && (psw_reg[0] || psw_reg[2]) |=> pc == $past(upd))
        else $error("higher branch taken with carry or zero");
    ls_take_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE4
        acc && ins_word[15:8] == pcx_pkg::OP_BRANCH_LOWER_SAME_UNSIGNED && psw_reg[0] |=> pc == $past(br_target))
        else $error("lower-same branch missed on carry");
    branch_flags_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE7
        acc && br_is && !psw_wr |=> $stable(psw_reg))
        else $error("branch changed condition codes");
    jump_illegal_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE8
        acc && ins_word[15:6] == pcx_pkg::OP_JMP && mode == pcx_pkg::MODE_REG
        |=> state_reg == pcx_pkg::ST_PUSH_PS && vec_reg == pcx_pkg::VEC_ILLEGAL)
        else $error("register-mode jump did not trap");
    odd_fetch_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE10
        state_reg == pcx_pkg::ST_IDLE && ctrl_reg && pc[0]
        |-> !ins_ready ##1 state_reg == pcx_pkg::ST_PUSH_PS && vec_reg == pcx_pkg::VEC_BUS_ERR)
        else $error("odd fetch did not trap");
    loop_back_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE16
        acc && ins_word[15:9] == pcx_pkg::OP_SOB && rsel != pcx_pkg::REG_PC
        |=> $past(upd) - pc <= 16'h007e && $stable(psw_reg) || $past(psw_wr))
        else $error("loop branched forward");
    push_dec_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE19
        state_reg == pcx_pkg::ST_PUSH_PS && mem_ack
        |=> mem_addr == sp && sp == $past(sp) - pcx_pkg::WORD_STEP && mem_wdata == $past(pc))
        else $error("push did not predecrement by two");

endmodule : pcx_exec

/* test/pcx_mem_model.sv */
`timescale 1ns/1ps
module pcx_mem_model (
    input wire logic mclk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] mem [0:32767];
    int dly = 0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 16'h0000;
    // word store, acks 1 to 4 cycles after it sees a request; data toggles otherwise
    always @(posedge mclk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && dly > 0)
            dly <= dly - 1;
        else if (mem_req && !mem_ack)
        begin
            mem_ack <= 1'b1;
            dly <= $urandom_range(3, 0);
            if (mem_we)
                mem[mem_addr[15:1]] <= mem_wdata;
            else
                mem_rdata <= mem[mem_addr[15:1]];
        end
    end
endmodule : pcx_mem_model

/* test/test_program_control_exec.sv */
`timescale 1ns/1ps
module test_program_control_exec;
    logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, e;
    logic [7:0] paddr = 8'h00, op, off;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic ins_valid = 1'b0, ins_ready, trap_req = 1'b0, trap_ack, psw_wr = 1'b0, mem_req, mem_we, mem_ack;
    logic [15:0] ins_word = 16'h0000, ins_dst = 16'h0000, trap_vec = 16'h0000, psw_wdata = 16'h0000;
    logic [15:0] fetch_addr, psw_out, mem_addr, mem_wdata, mem_rdata, pc, ps;
    int fails = 0, tests_run = 0;
    // clock, device and memory
    always #4 mclk = ~mclk;
    pcx_exec dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .fetch_addr(fetch_addr), .ins_valid(ins_valid), .ins_word(ins_word), .ins_dst(ins_dst),
        .ins_ready(ins_ready), .trap_req(trap_req), .trap_vec(trap_vec), .trap_ack(trap_ack), .psw_wr(psw_wr),
        .psw_wdata(psw_wdata), .psw_out(psw_out), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    pcx_mem_model mem_i (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    // expected next fetch address of a branch
    function automatic logic [15:0] br(input logic [7:0] o, input logic [3:0] f, input logic [7:0] d,
        input logic [15:0] p);
        logic t;
        t = f[2] | (f[3] ^ f[1]);
        if (o == pcx_pkg::OP_BGT)
            t = !t;
        if (o[7])
            t = (f[0] | f[2]) ^ (o == pcx_pkg::OP_BHI);
        return t ? p + 16'h0002 + {{7{d[7]}}, d, 1'b0} : p + 16'h0002;
    endfunction : br
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic idle;
        @(negedge mclk);
        while (ins_ready !== 1'b1)
            @(negedge mclk);
    endtask : idle
    // offer one instruction, wait for idle again
    task automatic exec(input logic [15:0] w, input logic [15:0] d);
        @(posedge mclk);
        {ins_valid, ins_word, ins_dst} <= {1'b1, w, d};
        idle();
        @(posedge mclk);
        ins_valid <= 1'b0;
        idle();
    endtask : exec
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        {e, r} = {pslverr, prdata};
        {psel, penable} <= 2'b00;
    endtask : apb
    // watchdog
    initial
    begin
        #400000;
        fails++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        void'($urandom(32'hb00e_dc31));
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        pc = 16'h0000;
        apb(1'b1, pcx_pkg::ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, pcx_pkg::ADDR_IRQ_MASK, 32'h0000_000f);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({r[30:0], e}, 32'h0000_0001);
        for (int i = 0; i < 40; i++)
        begin
            op = (i[1] ? pcx_pkg::OP_BHI : pcx_pkg::OP_BGT) + 8'(i[0]);
            off = (i < 4) ? 8'h80 : 8'($urandom);
            ps = 16'($urandom) & 16'h000f;
            @(posedge mclk);
            {psw_wr, psw_wdata} <= {1'b1, ps};
            @(posedge mclk);
            psw_wr <= 1'b0;
            exec({op, off}, 16'h0000);
            pc = br(op, ps[3:0], off, pc);
            chk(fetch_addr, pc);
            chk(psw_out, ps);
        end
        {mem_i.mem[2], mem_i.mem[3], mem_i.mem[32], mem_i.mem[33]} = 64'h0400_0000_0500_000f;
        exec({pcx_pkg::OP_JMP, pcx_pkg::MODE_REG, 3'h3}, 16'h0000);
        chk(fetch_addr, 16'h0400);
        chk(mem_i.mem[15'h7ffe], pc + 16'h0002);
        apb(1'b0, pcx_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        chk({r[3:0], irq}, 5'h0b);
        apb(1'b1, pcx_pkg::ADDR_IRQ_STAT, 32'h0000_000f);
        repeat (2) @(negedge mclk);
        chk(irq, 1'b0);
        exec({pcx_pkg::OP_JMP, pcx_pkg::MODE_DEFER, 3'h3}, 16'h1234);
        chk(fetch_addr, 16'h0000);
        exec({pcx_pkg::OP_JMP, 3'h6, 3'h1}, 16'h0101);
        chk(fetch_addr, 16'h0400);
        exec({pcx_pkg::OP_JSR, 3'h3, 3'h6, 3'h2}, 16'h0200);
        chk(fetch_addr, 16'h0200);
        chk(mem_i.mem[15'h7ffb], 16'h0000);
        exec({pcx_pkg::OP_RTS, 3'h3}, 16'h0000);
        chk(fetch_addr, 16'h0402);
        exec({pcx_pkg::OP_SOB, 3'h3, 6'h05}, 16'h0000);
        chk(fetch_addr, 16'h03fa);
        @(posedge mclk);
        {trap_req, trap_vec} <= {1'b1, 16'h0040};
        @(negedge mclk);
        while (trap_ack !== 1'b1)
            @(negedge mclk);
        @(posedge mclk);
        trap_req <= 1'b0;
        idle();
        chk({psw_out, fetch_addr}, 32'h000f_0500);
        chk(mem_i.mem[15'h7ffa], 16'h03fa);
        exec(pcx_pkg::OP_RTI, 16'h0000);
        chk({psw_out, fetch_addr}, 32'h0000_03fa);
        exec({pcx_pkg::OP_JSR, 9'h1f2}, 16'h0300);
        exec({pcx_pkg::OP_JSR, 9'h1de}, 16'h0000);
        chk({fetch_addr, mem_i.mem[15'h7ffb]}, 32'h03fc_0302);
        exec({pcx_pkg::OP_MARK, 6'h01}, 16'h0000);
        chk({fetch_addr, mem_addr}, 32'h0000_fff8);
        report_and_stop();
    end
endmodule : test_program_control_exec
